//--- hio_pkg.sv
package hio_pkg;

    // ==================================================================
    // register map (byte addresses)
    // ==================================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;

    // ==================================================================
    // control fields
    // ==================================================================
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_RISE_BIT = 1;
    localparam int CTRL_BUSY_ACC_BIT = 2;
    localparam int CTRL_SOFT_MEASURE_TRIGGER_IN_BIT = 3;
    localparam logic CTRL_EXT_RST = 1'b1;
    localparam logic CTRL_RISE_RST = 1'b0;
    localparam logic CTRL_BUSY_ACC_RST = 1'b0;

    // ==================================================================
    // status fields
    // ==================================================================
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PEND_BIT = 1;
    localparam int STAT_CONV_BIT = 2;
    localparam int STAT_PANEL_LSB = 8;

    // ==================================================================
    // interrupt fields, same layout in status and mask
    // ==================================================================
    localparam int IRQ_W = 4;
    localparam int IRQ_MEAS_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam int IRQ_DROP_BIT = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // ==================================================================
    // panel numbers
    // ==================================================================
    localparam int PSEL_W = 7;
    localparam int PANEL_W = 8;
    localparam logic [PANEL_W-1:0] PANEL_ALL_ZERO = 8'h80;
    localparam logic [PANEL_W-1:0] PANEL_RST = 8'h01;

    typedef struct packed {
        logic high;
        logic in;
        logic low;
    } judge_t;

    typedef struct packed {
        judge_t main_j;
        judge_t sub_j;
    } param_judge_t;

    typedef struct packed {
        param_judge_t p1;
        param_judge_t p2;
    } panel_judge_t;

    typedef struct packed {
        logic panel1_main_high_n;
        logic panel1_main_low_n;
        logic panel1_main_in_n;
        logic panel1_sub_high_n;
        logic panel1_sub_low_n;
        logic panel1_sub_in_n;
        logic panel2_main_high_n;
        logic panel2_main_low_n;
        logic panel2_main_in_n;
        logic panel2_sub_high_n;
        logic panel2_sub_low_n;
        logic panel2_sub_in_n;
    } judge_pins_t;

    typedef struct packed {
        logic sampling;
        logic contact;
        logic high_z;
        logic const_src;
        logic limit;
    } fault_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_JUDGE
    } meas_state_t;

endpackage : hio_pkg

//--- measure_trigger_in_edge_det.sv
module measure_trigger_in_edge_det (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_level,
    input wire logic i_rise_sel,
    output logic o_edge
);

    logic prev_r;

    // ==================================================================
    // previous level; idle pin is high, so reset there to avoid a
    // false rising edge right after reset
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= i_level;
        end
    end

    always_comb begin
        if (i_rise_sel) begin
            o_edge = i_level & ~prev_r;
        end else begin
            o_edge = ~i_level & prev_r;
        end
    end

endmodule : measure_trigger_in_edge_det

//--- handler_io_continuous_mode.sv
// Decided for this implementation: strobed register access and the register offsets.
module handler_io_continuous_mode
    import hio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_measure_trigger_in,
    input wire logic [PSEL_W-1:0] i_panel_select_n,
    input wire logic i_panel_load_strobe_n,
    input wire bus_req_t i_bus,
    output logic [31:0] o_rdata,
    output logic o_meas_start,
    output logic [PANEL_W-1:0] o_meas_panel,
    output logic o_panel_load,
    input wire logic i_adc_done,
    input wire logic i_judge_valid,
    input wire panel_judge_t i_judge,
    input wire logic i_out_of_bins,
    input wire fault_t i_fault,
    output logic o_measurement_done_n,
    output logic o_conversion_done_n,
    output judge_pins_t o_judge_n,
    output logic o_all_pass_n,
    output logic o_fault_out_n,
    output logic o_irq
);

    // ==================================================================
    // declarations
    // ==================================================================
    logic external_source_r;
    logic rise_sel_r;
    logic busy_acc_r;
    logic soft_measure_trigger_in_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [15:0] meas_count_r;
    logic pend_r;
    logic [PANEL_W-1:0] pend_panel_r;
    logic [PANEL_W-1:0] panel_r;
    logic [PANEL_W-1:0] sel_panel;
    logic [PANEL_W-1:0] start_panel;
    logic [PSEL_W-1:0] sel_bits;
    logic fault_any;
    logic fault_prev_r;
    logic pin_edge;
    logic measure_trigger_in_valid;
    logic busy;
    logic accept;
    logic drop;
    logic start;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    meas_state_t state_r;
    meas_state_t state_nxt;

    // ==================================================================
    // register writes
    // ==================================================================
    assign wr_ctrl = i_bus.wr && (i_bus.addr == OFS_CTRL);
    assign wr_stat = i_bus.wr && (i_bus.addr == OFS_IRQ_STAT);
    assign wr_mask = i_bus.wr && (i_bus.addr == OFS_IRQ_MASK);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            external_source_r <= CTRL_EXT_RST;
            rise_sel_r <= CTRL_RISE_RST;
            busy_acc_r <= CTRL_BUSY_ACC_RST;
        end else if (wr_ctrl) begin
            external_source_r <= i_bus.wdata[CTRL_EXT_BIT];
            rise_sel_r <= i_bus.wdata[CTRL_RISE_BIT];
            busy_acc_r <= i_bus.wdata[CTRL_BUSY_ACC_BIT];
        end
    end

    // soft trigger bit self-clears; only used with the internal source
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            soft_measure_trigger_in_r <= 1'b0;
        end else begin
            soft_measure_trigger_in_r <= wr_ctrl && i_bus.wdata[CTRL_SOFT_MEASURE_TRIGGER_IN_BIT]
                && !i_bus.wdata[CTRL_EXT_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask_r <= i_bus.wdata[IRQ_W-1:0];
        end
    end

    // ==================================================================
    // trigger edge and acceptance
    // ==================================================================
    measure_trigger_in_edge_det u_edge (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_level(i_measure_trigger_in),
        .i_rise_sel(rise_sel_r),
        .o_edge(pin_edge)
    );

    assign measure_trigger_in_valid = pin_edge && external_source_r;
    assign busy = (state_r != ST_IDLE);

    // with busy_acc_r set, an edge taken while busy is queued one deep; with busy_acc_r clear, or one already queued, the edge is dropped
    assign accept = measure_trigger_in_valid && (!busy || (busy_acc_r && !pend_r));
    assign drop = measure_trigger_in_valid && !accept;

    assign start = (state_r == ST_IDLE)
        && (accept || pend_r || soft_measure_trigger_in_r);

    // ==================================================================
    // panel number decode: all-zero select reads as the top panel
    // ==================================================================
    assign sel_bits = ~i_panel_select_n;

    always_comb begin
        if (i_panel_load_strobe_n) begin
            sel_panel = panel_r;
        end else if (sel_bits == '0) begin
            sel_panel = PANEL_ALL_ZERO;
        end else begin
            sel_panel = {1'b0, sel_bits};
        end
    end

    assign start_panel = pend_r ? pend_panel_r : sel_panel;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            panel_r <= PANEL_RST;
        end else if (accept) begin
            panel_r <= sel_panel;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_r <= 1'b0;
            pend_panel_r <= PANEL_RST;
        end else if (accept && (busy || pend_r)) begin
            pend_r <= 1'b1;
            pend_panel_r <= sel_panel;
        end else if (start) begin
            pend_r <= 1'b0;
        end
    end

    // ==================================================================
    // measurement sequence
    // ==================================================================
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (i_adc_done) begin
                    state_nxt = ST_JUDGE;
                end
            end
            ST_JUDGE: begin
                if (i_judge_valid) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_meas_start <= 1'b0;
            o_meas_panel <= PANEL_RST;
            o_panel_load <= 1'b0;
        end else begin
            o_meas_start <= start;
            o_panel_load <= start && (pend_r || !i_panel_load_strobe_n);
            if (start) begin
                o_meas_panel <= start_panel;
            end
        end
    end

    // ==================================================================
    // handshake outputs; both rise at start, fall as events
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conversion_done_n <= 1'b1;
        end else if (start) begin
            o_conversion_done_n <= 1'b1;
        end else if (state_r == ST_CONVERT && i_adc_done) begin
            o_conversion_done_n <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_measurement_done_n <= 1'b1;
        end else if (start) begin
            o_measurement_done_n <= 1'b1;
        end else if (state_r == ST_JUDGE && i_judge_valid) begin
            o_measurement_done_n <= 1'b0;
        end
    end

    // ==================================================================
    // judgment outputs, latched on the same edge as measurement done
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_judge_n <= '1;
            o_all_pass_n <= 1'b1;
        end else if (state_r == ST_JUDGE && i_judge_valid) begin
            o_judge_n.panel1_main_high_n <= ~i_judge.p1.main_j.high;
            o_judge_n.panel1_main_low_n <= ~i_judge.p1.main_j.low;
            o_judge_n.panel1_main_in_n <= ~i_judge.p1.main_j.in;
            o_judge_n.panel1_sub_high_n <= ~i_judge.p1.sub_j.high;
            o_judge_n.panel1_sub_low_n <= ~i_judge.p1.sub_j.low;
            o_judge_n.panel1_sub_in_n <= ~i_judge.p1.sub_j.in;
            o_judge_n.panel2_main_high_n <= ~i_judge.p2.main_j.high;
            o_judge_n.panel2_main_low_n <= ~i_judge.p2.main_j.low;
            o_judge_n.panel2_main_in_n <= ~i_judge.p2.main_j.in;
            o_judge_n.panel2_sub_high_n <= ~i_judge.p2.sub_j.high;
            o_judge_n.panel2_sub_low_n <= ~i_judge.p2.sub_j.low;
            o_judge_n.panel2_sub_in_n <= ~i_judge.p2.sub_j.in;
            o_all_pass_n <= ~(i_judge.p1.main_j.in && i_judge.p1.sub_j.in
                && i_judge.p2.main_j.in && i_judge.p2.sub_j.in
                && !i_out_of_bins);
        end
    end

    // ==================================================================
    // fault level
    // ==================================================================
    assign fault_any = |i_fault;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fault_out_n <= 1'b1;
            fault_prev_r <= 1'b0;
        end else begin
            o_fault_out_n <= ~fault_any;
            fault_prev_r <= fault_any;
        end
    end

    // ==================================================================
    // interrupts: set wins over a write-one clear in the same cycle
    // ==================================================================
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_MEAS_BIT] = (state_r == ST_JUDGE) && i_judge_valid;
        irq_set[IRQ_CONV_BIT] = (state_r == ST_CONVERT) && i_adc_done;
        irq_set[IRQ_FAULT_BIT] = fault_any && !fault_prev_r;
        irq_set[IRQ_DROP_BIT] = drop;
    end

    assign irq_clr = wr_stat ? i_bus.wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    // ==================================================================
    // completed-measurement counter, wraps
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meas_count_r <= 16'h0000;
        end else if (irq_set[IRQ_MEAS_BIT]) begin
            meas_count_r <= meas_count_r + 16'h0001;
        end
    end

    // ==================================================================
    // read data, one cycle after the read strobe and only then
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0000_0000;
        end else if (!i_bus.rd) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= 32'h0000_0000;
            case (i_bus.addr)
                OFS_CTRL: begin
                    o_rdata[CTRL_EXT_BIT] <= external_source_r;
                    o_rdata[CTRL_RISE_BIT] <= rise_sel_r;
                    o_rdata[CTRL_BUSY_ACC_BIT] <= busy_acc_r;
                end
                OFS_STATUS: begin
                    o_rdata[STAT_BUSY_BIT] <= busy;
                    o_rdata[STAT_PEND_BIT] <= pend_r;
                    o_rdata[STAT_CONV_BIT] <= ~o_conversion_done_n;
                    o_rdata[STAT_PANEL_LSB +: PANEL_W] <= o_meas_panel;
                end
                OFS_IRQ_STAT: begin
                    o_rdata[IRQ_W-1:0] <= irq_stat_r;
                end
                OFS_IRQ_MASK: begin
                    o_rdata[IRQ_W-1:0] <= irq_mask_r;
                end
                OFS_COUNT: begin
                    o_rdata[15:0] <= meas_count_r;
                end
                default: begin
                    o_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule : handler_io_continuous_mode

//--- handler_io_chk.sv
module handler_io_chk
    import hio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_measure_trigger_in,
    input wire bus_req_t i_bus,
    input wire logic i_adc_done,
    input wire logic i_judge_valid,
    input wire panel_judge_t i_judge,
    input wire logic i_out_of_bins,
    input wire fault_t i_fault,
    input wire logic o_meas_start,
    input wire logic o_measurement_done_n,
    input wire logic o_conversion_done_n,
    input wire judge_pins_t o_judge_n,
    input wire logic o_all_pass_n,
    input wire logic o_fault_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ext_r, rise_r, acc_r, busy_r, prev_r, vedge, idle, all_in;
    // ====
    // control shadow
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_r <= CTRL_EXT_RST;
            rise_r <= CTRL_RISE_RST;
            acc_r <= CTRL_BUSY_ACC_RST;
        end else if (i_bus.wr && i_bus.addr == OFS_CTRL) begin
            ext_r <= i_bus.wdata[CTRL_EXT_BIT];
            rise_r <= i_bus.wdata[CTRL_RISE_BIT];
            acc_r <= i_bus.wdata[CTRL_BUSY_ACC_BIT];
        end
    end
    // ====
    // trigger and busy tracking
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_r <= 1'b0;
            prev_r <= 1'b1;
        end else begin
            busy_r <= (busy_r || o_meas_start) && !i_judge_valid;
            prev_r <= i_measure_trigger_in;
        end
    end
    assign vedge = rise_r ? !prev_r && i_measure_trigger_in
                          : prev_r && !i_measure_trigger_in;
    // idle after reset has both done lines high, so it is left out
    assign idle = !o_measurement_done_n && !o_conversion_done_n && !busy_r
                  && !o_meas_start;
    assign all_in = i_judge.p1.main_j.in && i_judge.p1.sub_j.in
                    && i_judge.p2.main_j.in && i_judge.p2.sub_j.in
                    && !i_out_of_bins;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ====
    // properties
    done_after_judge_a: assert property ($fell(o_measurement_done_n)
        |-> $past(i_judge_valid)) else $error("done without judgment");
    judge_pins_a: assert property ($fell(o_measurement_done_n)
        |-> o_judge_n.panel1_sub_high_n == !$past(i_judge.p1.sub_j.high)
        && o_judge_n.panel2_main_low_n == !$past(i_judge.p2.main_j.low))
        else $error("judgment pin wrong");
    all_pass_a: assert property ($fell(o_measurement_done_n)
        |-> o_all_pass_n == !$past(all_in)) else $error("all-pass wrong");
    conv_after_adc_a: assert property ($fell(o_conversion_done_n)
        |-> $past(i_adc_done)) else $error("conversion done early");
    start_clears_a: assert property (o_meas_start
        |-> o_measurement_done_n && o_conversion_done_n)
        else $error("done lines low at start");
    edge_start_a: assert property (ext_r && idle && vedge
        |-> ##[1:2] o_meas_start) else $error("valid edge not taken");
    busy_drop_a: assert property (ext_r && !acc_r && busy_r
        && !i_judge_valid && vedge |-> ##1 !o_meas_start ##1 !o_meas_start)
        else $error("edge taken while busy");
    int_ignore_a: assert property (!ext_r && idle && vedge && !i_bus.wr
        && !$past(i_bus.wr) && !$past(i_bus.wr, 2)
        |-> ##1 !o_meas_start ##1 !o_meas_start)
        else $error("pin started internal mode");
    fault_set_a: assert property (|i_fault |=> !o_fault_out_n)
        else $error("fault not shown");
    fault_clr_a: assert property (!(|i_fault) |=> o_fault_out_n)
        else $error("fault shown without cause");
    cover property (busy_r && vedge && acc_r);
    cover property ($fell(o_measurement_done_n) && !o_all_pass_n);
    cover property (rise_r && o_meas_start);
endmodule : handler_io_chk

bind handler_io_continuous_mode handler_io_chk chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus),
    .i_measure_trigger_in(i_measure_trigger_in), .i_adc_done(i_adc_done),
    .i_judge_valid(i_judge_valid), .i_judge(i_judge),
    .i_out_of_bins(i_out_of_bins), .i_fault(i_fault),
    .o_meas_start(o_meas_start), .o_judge_n(o_judge_n),
    .o_measurement_done_n(o_measurement_done_n),
    .o_conversion_done_n(o_conversion_done_n),
    .o_all_pass_n(o_all_pass_n), .o_fault_out_n(o_fault_out_n)
);

//--- handler_model.sv
module handler_model (
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic [7:0] i_panel,
    input wire logic i_conversion_done_n,
    output logic o_measure_trigger_in,
    output logic [6:0] o_sel_n,
    output logic o_load_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 0;
    logic conv_q = 1'b1;
    initial o_measure_trigger_in = 1'b1;
    initial o_sel_n = 7'h7F;
    initial o_load_n = 1'b1;
    // low for two cycles: one valid edge whichever direction is chosen
    always @(posedge i_clk) begin
        conv_q <= i_conversion_done_n;
        if (i_fire) begin
            o_sel_n <= ~i_panel[6:0];
            o_load_n <= 1'b0;
            o_measure_trigger_in <= 1'b0;
            hold <= 2;
        end else if (hold > 0) begin
            hold <= hold - 1;
            o_measure_trigger_in <= hold == 1;
        end
        // part swapped only now; select lines then wander
        if (conv_q && !i_conversion_done_n && !i_fire) begin
            o_sel_n <= ~o_sel_n;
            o_load_n <= 1'b1;
        end
    end
endmodule : handler_model

//--- testbench.sv
module testbench
    import hio_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, measure_trigger_in, load_n, adc, jv, oob, fire, irq, start, pload;
    logic mdone_n, cdone_n, apass_n, fault_n;
    logic [6:0] sel_n;
    logic [7:0] fpanel, mpanel;
    logic [31:0] rdata;
    bus_req_t bus;
    panel_judge_t judge;
    fault_t fault;
    judge_pins_t pins;
    int fails, n_compared, seed, count, n_starts, k;
    int exp_q[$];

    always #12.5 clk = ~clk;

    handler_io_continuous_mode dut (
        .i_clk(clk), .i_rstn(rstn), .i_measure_trigger_in(measure_trigger_in),
        .i_panel_select_n(sel_n), .i_panel_load_strobe_n(load_n),
        .i_bus(bus), .o_rdata(rdata), .o_meas_start(start),
        .o_meas_panel(mpanel), .o_panel_load(pload), .i_adc_done(adc),
        .i_judge_valid(jv), .i_judge(judge), .i_out_of_bins(oob),
        .i_fault(fault), .o_measurement_done_n(mdone_n),
        .o_conversion_done_n(cdone_n), .o_judge_n(pins),
        .o_all_pass_n(apass_n), .o_fault_out_n(fault_n), .o_irq(irq)
    );
    handler_model handler (
        .i_clk(clk), .i_fire(fire), .i_panel(fpanel),
        .i_conversion_done_n(cdone_n), .o_measure_trigger_in(measure_trigger_in), .o_sel_n(sel_n),
        .o_load_n(load_n)
    );

    // ====
    // helpers
    task automatic chk(input string w, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask : bus_rd
    function automatic logic [11:0] exp_pins(input logic [11:0] j);
        logic [11:0] r;
        for (int g = 0; g < 4; g++) r[3*g +: 3] = ~{j[3*g+2], j[3*g], j[3*g+1]};
        return r;
    endfunction : exp_pins
    function automatic logic [7:0] rp();
        return 8'(({$random(seed)} % 128) + 1);
    endfunction : rp
    task automatic pulse(input logic [7:0] p, input bit want);
        @(posedge clk);
        fpanel <= p;
        fire <= 1'b1;
        if (want) exp_q.push_back(p);
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse
    task automatic wait_start();
        int c0;
        c0 = n_starts;
        for (int i = 0; i < 20 && n_starts == c0; i++) @(posedge clk) #1;
        chk("start", n_starts, c0 + 1);
    endtask : wait_start
    task automatic finish(input logic [11:0] j, input logic ob);
        repeat (2) @(posedge clk);
        adc <= 1'b1;
        @(posedge clk);
        adc <= 1'b0;
        #1 chk("conv_n", cdone_n, 0);
        chk("done_n", mdone_n, 1);
        @(posedge clk);
        judge <= j;
        oob <= ob;
        jv <= 1'b1;
        @(posedge clk);
        jv <= 1'b0;
        judge <= ~j;
        #1 chk("done_n", mdone_n, 0);
        chk("pins", pins, exp_pins(j));
        chk("pass_n", apass_n, !(j[10] && j[7] && j[4] && j[1] && !ob));
        count++;
    endtask : finish
    // mode 1: second edge while busy, mode 2: same but expected to queue
    task automatic meas(input logic [7:0] p, p2, input bit pass, int mode);
        logic [31:0] r;
        r = pass ? 32'h492 : $random(seed);
        pulse(p, 1'b1);
        wait_start();
        if (mode > 0) pulse(p2, mode == 2);
        finish(r[11:0], r[12]);
        if (mode == 2) wait_start();
        if (mode == 2) finish(~r[11:0], 1'b0);
    endtask : meas
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // ====
    // result model
    always @(posedge clk) begin
        if (rstn && start === 1'b1) begin
            n_starts++;
            chk("load", pload, 1);
            if (exp_q.size() == 0) chk("extra start", 1, 0);
            else chk("panel", mpanel, exp_q.pop_front());
        end
    end
    initial begin
        #75000;
        fails++;
        give_verdict();
    end

    // ====
    // tests
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        bus = '0;
        adc = 1'b0;
        jv = 1'b0;
        judge = '0;
        oob = 1'b0;
        fault = '0;
        fire = 1'b0;
        fpanel = 8'h01;
        seed = 32'h7A1EBC59;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk("idle", {mdone_n, cdone_n, apass_n, fault_n}, 4'hF);
        chk("pins", pins, 12'hFFF);
        bus_rd(OFS_CTRL, 32'h1);
        bus_rd(8'h20, 32'h0);
        bus_wr(OFS_IRQ_MASK, 32'h1);
        $display("test reset done");
        meas(8'h01, 8'h00, 0, 0);
        meas(8'h80, 8'h00, 0, 0);
        meas(8'h40, 8'h00, 1, 0);
        for (k = 0; k < 4; k++) meas(rp(), 8'h00, 0, 0);
        chk("irq", irq, 1);
        bus_rd(OFS_IRQ_STAT, 32'h3);
        bus_wr(OFS_IRQ_STAT, 32'h3);
        #1 chk("irq", irq, 0);
        $display("test falling edge done");
        bus_wr(OFS_CTRL, 32'h3);
        meas(rp(), 8'h00, 0, 0);
        bus_wr(OFS_CTRL, 32'h0);
        pulse(8'h05, 1'b0);
        repeat (12) @(posedge clk);
        exp_q.push_back(8'h05);
        bus_wr(OFS_CTRL, 32'h8);
        wait_start();
        finish(12'h000, 1'b0);
        bus_wr(OFS_CTRL, 32'h1);
        $display("test edge and source done");
        meas(8'h11, 8'h22, 0, 1);
        repeat (6) @(posedge clk);
        bus_rd(OFS_IRQ_STAT, 32'hB);
        bus_wr(OFS_IRQ_STAT, 32'hF);
        bus_wr(OFS_CTRL, 32'h5);
        meas(8'h30, 8'h7F, 0, 2);
        bus_wr(OFS_CTRL, 32'h1);
        $display("test busy done");
        k = {$random(seed)} % 5;
        @(posedge clk);
        fault <= 5'h01 << k;
        @(posedge clk);
        #1 chk("fault_n", fault_n, 0);
        bus_rd(OFS_IRQ_STAT, 32'h7);
        @(posedge clk);
        fault <= '0;
        @(posedge clk);
        #1 chk("fault_n", fault_n, 1);
        bus_rd(OFS_COUNT, count);
        bus_rd(OFS_STATUS, 32'h7F04);
        chk("left", exp_q.size(), 0);
        $display("test fault done");
        give_verdict();
    end
endmodule : testbench
